// ### rtl/ciapr_defines.svh
`ifndef CIAPR_DEFINES_SVH
`define CIAPR_DEFINES_SVH

// register byte offsets
`define CIAPR_OFF_MON        8'h00
`define CIAPR_OFF_INT        8'h08
`define CIAPR_OFF_RST        8'h0c

// reset values
`define CIAPR_RST_MON        32'h0000_0000
`define CIAPR_RST_INT        32'h0000_0000
`define CIAPR_RST_RST        32'h0000_0000

// clock interrupt register fields
`define CIAPR_FLAG_LSB       0
`define CIAPR_IE_LSB         8
`define CIAPR_CLR_LSB        16
`define CIAPR_IE_MASK        7'h7f
`define CIAPR_BIT_HXT_STUCK  7
`define CIAPR_BIT_PLL_MIE    14
`define CIAPR_BIT_LXT_MIE    13

// monitor control register fields
`define CIAPR_BIT_NMI_EN     0

// peripheral reset register: writable bits, rest reserved zero
`define CIAPR_RST_MASK       32'hc030_7e03
`define CIAPR_BIT_CAN1       31
`define CIAPR_BIT_CAN0       30
`define CIAPR_BIT_TMR20      21
`define CIAPR_BIT_TMR19      20
`define CIAPR_BIT_USART0     14
`define CIAPR_BIT_TMR7       13
`define CIAPR_BIT_SPI0       12
`define CIAPR_BIT_TMR0       11
`define CIAPR_BIT_ADC1       10
`define CIAPR_BIT_ADC0       9
`define CIAPR_BIT_CMP        1
`define CIAPR_BIT_CFG        0

// synchroniser depth for clock monitor inputs
`define CIAPR_SYNC_STAGES    3

`endif

// ### rtl/ciapr_pkg.sv
package ciapr_pkg;

  typedef logic [31:0] ciapr_word_t;
  typedef logic [7:0]  ciapr_flags_t;
  typedef logic [6:0]  ciapr_ie_t;

endpackage : ciapr_pkg

// ### rtl/ciapr_sync.sv
`timescale 1ns/1ps
`include "ciapr_defines.svh"

module ciapr_sync
  import ciapr_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // three flop chain, first stage read only by second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a change once second and third stage agree
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      level_out <= '0;
    else
      level_out <= (~(stage2 ^ stage3) & stage3)
                 | ((stage2 ^ stage3) & level_out);
  end

endmodule : ciapr_sync

// ### rtl/ciapr_top.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "ciapr_defines.svh"

module ciapr_top
  import ciapr_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              pll_stable,
  input  wire logic              fast_xtal_stable,
  input  wire logic              fast_rc_stable,
  input  wire logic              slow_xtal_stable,
  input  wire logic              slow_rc_stable,
  input  wire logic              fast_xtal_stuck,
  input  wire logic              pll_stuck,
  input  wire logic              slow_xtal_stuck,
  output logic                   irq,
  output logic                   nmi,
  output logic                   can_unit1_hold,
  output logic                   can_unit0_hold,
  output logic                   timer_unit20_hold,
  output logic                   timer_unit19_hold,
  output logic                   usart_unit0_hold,
  output logic                   timer_unit7_hold,
  output logic                   spi_unit0_hold,
  output logic                   timer_unit0_hold,
  output logic                   adc_unit1_hold,
  output logic                   adc_unit0_hold,
  output logic                   comparator_hold,
  output logic                   sysconfig_hold
);

  // address match against an 8-bit offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  ciapr_flags_t flags;
  ciapr_ie_t    ie;
  ciapr_word_t  hold;
  logic         clock_monitor_nmi_en;
  ciapr_flags_t mon_level;
  ciapr_flags_t mon_prev;
  ciapr_flags_t events;
  ciapr_flags_t gate;
  ciapr_flags_t set_vec;
  ciapr_flags_t clr_vec;
  ciapr_flags_t next_flags;
  logic         wr_int;
  logic         wr_rst;
  logic         wr_mon;
  logic         nmi_set_wr;
  logic         next_irq;

  // monitor inputs, order matches flag bits 7..0
  ciapr_sync #(
    .WIDTH     (8)
  ) u_sync (
    .clk       (clk),
    .reset     (reset),
    .async_in  ({fast_xtal_stuck, pll_stuck, slow_xtal_stuck, pll_stable,
                 fast_xtal_stable, fast_rc_stable, slow_xtal_stable,
                 slow_rc_stable}),
    .level_out (mon_level)
  );

  // previous filtered level for rising edge detection
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mon_prev <= '0;
    else
      mon_prev <= mon_level;
  end

  // write decode
  assign wr_int     = wr && hit(addr, `CIAPR_OFF_INT);
  assign wr_rst     = wr && hit(addr, `CIAPR_OFF_RST);
  assign wr_mon     = wr && hit(addr, `CIAPR_OFF_MON);
  assign nmi_set_wr = wr_mon && wdata[`CIAPR_BIT_NMI_EN];

  // set and clear vectors for the eight flags
  assign events  = mon_level & ~mon_prev;
  assign gate    = {3'b111, ie[4:0]};
  assign set_vec = events & gate;
  assign clr_vec = (wr_int ? wdata[`CIAPR_CLR_LSB +: 8] : 8'h00)
                 | {nmi_set_wr, 7'h00};
  assign next_flags = (flags & ~clr_vec) | set_vec;

  // flags: hardware set wins over software clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      flags <= 8'(`CIAPR_RST_INT);
    else
      flags <= next_flags;
  end

  // interrupt enables, bits 14..8
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ie <= '0;
    else if (wr_int)
      ie <= wdata[`CIAPR_IE_LSB +: 7] & `CIAPR_IE_MASK;
  end

  // clock monitor nmi enable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      clock_monitor_nmi_en <= 1'b0;
    else if (wr_mon)
      clock_monitor_nmi_en <= wdata[`CIAPR_BIT_NMI_EN];
  end

  // peripheral reset holds, reserved bits stay zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      hold <= `CIAPR_RST_RST;
    else if (wr_rst)
      hold <= wdata & `CIAPR_RST_MASK;
  end

  // hold outputs straight from the register bits
  assign can_unit1_hold    = hold[`CIAPR_BIT_CAN1];
  assign can_unit0_hold    = hold[`CIAPR_BIT_CAN0];
  assign timer_unit20_hold = hold[`CIAPR_BIT_TMR20];
  assign timer_unit19_hold = hold[`CIAPR_BIT_TMR19];
  assign usart_unit0_hold  = hold[`CIAPR_BIT_USART0];
  assign timer_unit7_hold  = hold[`CIAPR_BIT_TMR7];
  assign spi_unit0_hold    = hold[`CIAPR_BIT_SPI0];
  assign timer_unit0_hold  = hold[`CIAPR_BIT_TMR0];
  assign adc_unit1_hold    = hold[`CIAPR_BIT_ADC1];
  assign adc_unit0_hold    = hold[`CIAPR_BIT_ADC0];
  assign comparator_hold   = hold[`CIAPR_BIT_CMP];
  assign sysconfig_hold    = hold[`CIAPR_BIT_CFG];

  // request: stable flags already gated, monitor flags 6 and 5 by their enables, flag 7 only to nmi
  assign next_irq = (|next_flags[4:0])
                  | (next_flags[6] & ie[6])
                  | (next_flags[5] & ie[5]);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq <= 1'b0;
      nmi <= 1'b0;
    end
    else
    begin
      irq <= next_irq;
      nmi <= next_flags[`CIAPR_BIT_HXT_STUCK];
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata <= '0;
    else if (rd && hit(addr, `CIAPR_OFF_INT))
      rdata <= {16'h0000, 1'b0, ie, flags};
    else if (rd && hit(addr, `CIAPR_OFF_RST))
      rdata <= hold;
    else if (rd && hit(addr, `CIAPR_OFF_MON))
      rdata <= {31'h0, clock_monitor_nmi_en};
    else
      rdata <= '0;
  end

  // checks
  sequence int_write_s(int b);
    wr && hit(addr, `CIAPR_OFF_INT) && wdata[b];
  endsequence

  sequence clear_write_s(int b);
    wr && hit(addr, `CIAPR_OFF_INT) && wdata[`CIAPR_CLR_LSB + b];
  endsequence

  sequence rise_s(int b);
    mon_level[b] && !mon_prev[b];
  endsequence

  fast_rc_en_a: assert property (@(posedge clk) disable iff (reset)
    wr_int |=> ie[2] == $past(wdata[10]))
    else $error("fast rc enable did not follow write");

  slow_xtal_en_a: assert property (@(posedge clk) disable iff (reset)
    wr_int |=> ie[1] == $past(wdata[9]))
    else $error("slow crystal enable did not follow write");

  slow_rc_en_a: assert property (@(posedge clk) disable iff (reset)
    !wr_int |=> $stable(ie[0]))
    else $error("slow rc enable changed without write");

  slow_rc_set_a: assert property (@(posedge clk) disable iff (reset)
    int_write_s(8) |=> ie[0])
    else $error("slow rc enable not set by write");

  xtal_stuck_set_a: assert property (@(posedge clk) disable iff (reset)
    rise_s(7) |=> flags[7])
    else $error("crystal stuck flag not set");

  nmi_clear_a: assert property (@(posedge clk) disable iff (reset)
    wr_mon && wdata[0] && !set_vec[7] |=> !flags[7] ##1 nmi == flags[7])
    else $error("nmi enable write did not clear stuck flag");

  pll_stuck_clr_a: assert property (@(posedge clk) disable iff (reset)
    clear_write_s(6) ##0 !set_vec[6] |=> !flags[6])
    else $error("pll stuck flag not cleared");

  slow_stuck_a: assert property (@(posedge clk) disable iff (reset)
    rise_s(5) ##1 ie[5] && !wr_int |-> flags[5] ##1 irq)
    else $error("slow crystal stuck flag or request wrong");

  pll_stable_a: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[4]) |-> $past(ie[4]) && $past(events[4]))
    else $error("pll stable flag set without enable");

  fast_xtal_stable_a: assert property (@(posedge clk) disable iff (reset)
    rise_s(3) ##0 ie[3] |=> flags[3])
    else $error("fast crystal stable flag not set");

  fast_rc_stable_a: assert property (@(posedge clk) disable iff (reset)
    rise_s(2) ##0 !ie[2] && !flags[2] |=> !flags[2])
    else $error("fast rc flag set while disabled");

  slow_xtal_stab_a: assert property (@(posedge clk) disable iff (reset)
    rise_s(1) ##0 ie[1] ##1 !wr_int |-> flags[1] ##1 irq)
    else $error("slow crystal stable flag or request missing");

  slow_rc_stable_a: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[0]) |-> $past(ie[0]))
    else $error("slow rc flag set without enable");

  ack_holds_a: assert property (@(posedge clk) disable iff (reset)
    clear_write_s(3) ##0 !set_vec[3] ##1 !set_vec[3] [*3]
      |=> !flags[3])
    else $error("acknowledged flag did not stay clear");

  zero_clear_a: assert property (@(posedge clk) disable iff (reset)
    wr_int && wdata[23:16] == 8'h00 |=>
      flags == ($past(flags) | $past(set_vec)))
    else $error("zero write changed a flag");

  hold_reset_a: assert property (@(posedge clk)
    reset |=> hold == 32'h0000_0000 && !sysconfig_hold)
    else $error("peripheral holds not zero after reset");

  timer_hold_a: assert property (@(posedge clk) disable iff (reset)
    wr_rst |=> timer_unit20_hold == $past(wdata[21]) &&
      timer_unit0_hold == $past(wdata[11]))
    else $error("timer hold did not follow write");

  can_hold_a: assert property (@(posedge clk) disable iff (reset)
    wr_rst |=> can_unit1_hold == $past(wdata[31]) &&
      spi_unit0_hold == $past(wdata[12]))
    else $error("can or spi hold did not follow write");

  adc_hold_a: assert property (@(posedge clk) disable iff (reset)
    !wr_rst |=> $stable(adc_unit1_hold) && $stable(adc_unit0_hold) &&
      $stable(comparator_hold))
    else $error("adc or comparator hold changed without write");

  cfg_hold_a: assert property (@(posedge clk) disable iff (reset)
    wr_rst |=> sysconfig_hold == $past(wdata[0]))
    else $error("configuration hold did not follow write");

  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    rd && hit(addr, `CIAPR_OFF_RST) |=> (rdata & ~`CIAPR_RST_MASK) == 0)
    else $error("reserved reset bits read nonzero");

  request_a: assert property (@(posedge clk) disable iff (reset)
    |flags[4:0] && clr_vec == 8'h00 |=> irq)
    else $error("request missing while stable flag set");

  pll_stuck_req_a: assert property (@(posedge clk) disable iff (reset)
    flags[6] && ie[6] && !wr_int |=> irq)
    else $error("pll stuck request missing");

  monitor_quiet_a: assert property (@(posedge clk) disable iff (reset)
    !(|flags[4:0]) && !(flags[6] && ie[6]) && !(flags[5] && ie[5]) &&
      set_vec[6:0] == 7'h00 |=> !irq)
    else $error("request raised without an enabled flag");

  adc_follow_a: assert property (@(posedge clk) disable iff (reset)
    wr_rst |=> adc_unit1_hold == $past(wdata[10]) &&
      adc_unit0_hold == $past(wdata[9]) &&
      comparator_hold == $past(wdata[1]))
    else $error("adc or comparator hold did not follow write");

  timer_mid_a: assert property (@(posedge clk) disable iff (reset)
    wr_rst |=> timer_unit19_hold == $past(wdata[20]) &&
      timer_unit7_hold == $past(wdata[13]))
    else $error("timer 19 or 7 hold did not follow write");

  can0_usart_a: assert property (@(posedge clk) disable iff (reset)
    wr_rst |=> can_unit0_hold == $past(wdata[30]) &&
      usart_unit0_hold == $past(wdata[14]))
    else $error("can0 or usart hold did not follow write");

  rdata_idle_a: assert property (@(posedge clk) disable iff (reset)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data not idle after a non-read cycle");

  nmi_follow_a: assert property (@(posedge clk) disable iff (reset)
    flags[7] && clr_vec[7] == 1'b0 |=> nmi)
    else $error("nmi dropped while stuck flag set");

endmodule : ciapr_top

// ### test/tb.sv
`timescale 1ns/1ps
`include "ciapr_defines.svh"

module tb
  import ciapr_pkg::*;
;
  logic        clk;
  logic        reset;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [7:0]  mon;
  logic        irq;
  logic        nmi;
  logic [11:0] holds;
  int          fails;
  int          compares;

  ciapr_top #(.ADDR_W(8)) u_dut (
    .clk               (clk),
    .reset             (reset),
    .addr              (addr),
    .wdata             (wdata),
    .wr                (wr),
    .rd                (rd),
    .rdata             (rdata),
    .pll_stable        (mon[4]),
    .fast_xtal_stable  (mon[3]),
    .fast_rc_stable    (mon[2]),
    .slow_xtal_stable  (mon[1]),
    .slow_rc_stable    (mon[0]),
    .fast_xtal_stuck   (mon[7]),
    .pll_stuck         (mon[6]),
    .slow_xtal_stuck   (mon[5]),
    .irq               (irq),
    .nmi               (nmi),
    .can_unit1_hold    (holds[11]),
    .can_unit0_hold    (holds[10]),
    .timer_unit20_hold (holds[9]),
    .timer_unit19_hold (holds[8]),
    .usart_unit0_hold  (holds[7]),
    .timer_unit7_hold  (holds[6]),
    .spi_unit0_hold    (holds[5]),
    .timer_unit0_hold  (holds[4]),
    .adc_unit1_hold    (holds[3]),
    .adc_unit0_hold    (holds[2]),
    .comparator_hold   (holds[1]),
    .sysconfig_hold    (holds[0])
  );

  // 40 mhz system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // value checks, counted
  task automatic chk(input logic [31:0] exp, input logic [31:0] got,
                     input string msg);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s exp %h got %h", $time, msg, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input logic exp, input logic got, input string msg);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s exp %b got %b", $time, msg, exp, got);
    end
  endtask : chk_bit

  // one-cycle bus strobes
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string msg);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(exp, rdata, msg);
  endtask : rd_chk

  // drive one monitor input and let the synchroniser settle
  task automatic set_mon(input int idx, input logic v);
    @(posedge clk);
    mon[idx] <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask : set_mon

  // expected hold outputs for a reset register word
  function automatic logic [11:0] exp_hold(input logic [31:0] w);
    return {w[31], w[30], w[21], w[20], w[14], w[13], w[12], w[11],
            w[10], w[9], w[1], w[0]};
  endfunction : exp_hold

  // reset values and the peripheral hold bits one by one
  task automatic t_periph;
    logic [31:0] v;
    chk_bit(1'b0, |holds, "holds after reset");
    rd_chk(`CIAPR_OFF_RST, 32'h0000_0000, "rst reg reset");
    rd_chk(`CIAPR_OFF_INT, 32'h0000_0000, "int reg reset");
    rd_chk(`CIAPR_OFF_MON, 32'h0000_0000, "mon reg reset");
    @(posedge clk);
    #1;
    chk(32'h0000_0000, rdata, "read data idle");
    for (int b = 0; b < 32; b++)
    begin
      v = 32'h0000_0001 << b;
      if ((v & `CIAPR_RST_MASK) != 32'h0000_0000)
      begin
        wr_reg(`CIAPR_OFF_RST, v);
        rd_chk(`CIAPR_OFF_RST, v, "rst reg bit");
        chk({20'h00000, exp_hold(v)}, {20'h00000, holds}, "hold");
      end
    end
    wr_reg(`CIAPR_OFF_RST, `CIAPR_RST_MASK);
    chk_bit(1'b1, &holds, "all held");
    wr_reg(`CIAPR_OFF_RST, 32'h0000_0000);
    chk_bit(1'b0, |holds, "all released");
    wr_reg(8'h44, 32'hffff_ffff);
    rd_chk(8'h44, 32'h0000_0000, "unmapped read");
    chk_bit(1'b0, |holds, "unmapped write");
    $display("test t_periph done");
  endtask : t_periph

  // stabilization flags: gating, w1c, zero writes, no re-set
  task automatic t_stable;
    logic [31:0] ie;
    wr_reg(`CIAPR_OFF_INT, 32'h0000_7f00);
    rd_chk(`CIAPR_OFF_INT, 32'h0000_7f00, "enables rw");
    for (int i = 0; i < 5; i++)
    begin
      ie = 32'h0000_0100 << i;
      wr_reg(`CIAPR_OFF_INT, 32'h0000_0000);
      set_mon(i, 1'b1);
      rd_chk(`CIAPR_OFF_INT, 32'h0000_0000, "gated off");
      chk_bit(1'b0, irq, "irq gated off");
      set_mon(i, 1'b0);
      wr_reg(`CIAPR_OFF_INT, ie);
      set_mon(i, 1'b1);
      rd_chk(`CIAPR_OFF_INT, ie | (32'h1 << i), "flag set");
      chk_bit(1'b1, irq, "irq set");
      wr_reg(`CIAPR_OFF_INT, ie);
      rd_chk(`CIAPR_OFF_INT, ie | (32'h1 << i), "zero clear");
      wr_reg(`CIAPR_OFF_INT, ie | (32'h0001_0000 << i));
      repeat (8) @(posedge clk);
      rd_chk(`CIAPR_OFF_INT, ie, "flag cleared");
      chk_bit(1'b0, irq, "irq cleared");
      set_mon(i, 1'b0);
    end
    $display("test t_stable done");
  endtask : t_stable

  // clock-stuck flags, their clears and the nmi path
  task automatic t_stuck;
    logic [31:0] ie;
    for (int j = 5; j < 8; j++)
    begin
      ie = (j == 7) ? 32'h0000_0000 : (32'h0000_0100 << j);
      wr_reg(`CIAPR_OFF_INT, ie);
      set_mon(j, 1'b1);
      rd_chk(`CIAPR_OFF_INT, ie | (32'h1 << j), "stuck set");
      chk_bit(j != 7, irq, "stuck irq");
      chk_bit(j == 7, nmi, "stuck nmi");
      wr_reg(`CIAPR_OFF_INT, ie | (32'h0001_0000 << j));
      rd_chk(`CIAPR_OFF_INT, ie, "stuck cleared");
      chk_bit(1'b0, irq | nmi, "stuck quiet");
      set_mon(j, 1'b0);
    end
    set_mon(7, 1'b1);
    chk_bit(1'b1, nmi, "nmi again");
    wr_reg(`CIAPR_OFF_MON, 32'h0000_0001);
    rd_chk(`CIAPR_OFF_INT, 32'h0000_0000, "nmi enable clear");
    rd_chk(`CIAPR_OFF_MON, 32'h0000_0001, "nmi enable rw");
    chk_bit(1'b0, nmi, "nmi dropped");
    set_mon(7, 1'b0);
    $display("test t_stuck done");
  endtask : t_stuck

  // mid-run reset clears every register and hold
  task automatic t_reset;
    wr_reg(`CIAPR_OFF_RST, `CIAPR_RST_MASK);
    wr_reg(`CIAPR_OFF_INT, 32'h0000_7f00);
    chk_bit(1'b1, &holds, "held before reset");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit(1'b0, |holds, "holds after mid reset");
    rd_chk(`CIAPR_OFF_RST, 32'h0000_0000, "rst reg mid reset");
    rd_chk(`CIAPR_OFF_INT, 32'h0000_0000, "int reg mid reset");
    rd_chk(`CIAPR_OFF_MON, 32'h0000_0000, "mon reg mid reset");
    $display("test t_reset done");
  endtask : t_reset

  // verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("MISMATCH %0t run did not finish", $time);
    end_of_test();
  end

  // main sequence
  initial
  begin
    fails    = 0;
    compares = 0;
    reset    = 1'b1;
    addr     = 8'h00;
    wdata    = 32'h0000_0000;
    wr       = 1'b0;
    rd       = 1'b0;
    mon      = 8'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_periph();
    t_stable();
    t_stuck();
    t_reset();
    end_of_test();
  end
endmodule : tb
